// File: verilog/irsm_shared_mem.sv
// shared-memory sram controller, indexed configuration and fast-ir paths
// Function
// - host reaches config via index/data ports, 20-bit memory address.
// - dma pins serve as local memory address outputs in shared mode.
// - drive 15-bit sram address plus active-low read, write, select.
// - control host/local data buffer via enable and direction outputs.
// - local transfers run with buffer isolated, host bus untouched.
// - arbitrate simultaneous host and fast-ir requests, grant one.
// - on transmit, read packet from sram and pass it to transceiver.
// - during reception write incoming bytes into sram.
// - pulse interrupt when a complete packet sits in sram.
// - page registers choose which sram part shows in 8k window.
// - up to 32k sram; smaller parts simply alias upper bits.
// - window upper 4k is transmit page, lower 4k receive page.
// - transmit page in sram 4000h-7fffh, receive page in 0000h-3fffh.
// - each page may start on any 1k boundary inside its half.
// - shared mode when op straps read 0,1,1.
// - default straps choose one of eight reset sets.
// - power-down control always resets to 02h.
// - mode identification reads e3h in shared mode, e2h otherwise, read-only.
// - dma select reset 00h for 000-011, then c8h, d0h, c4h, d4h.
// - interrupt config and serial base reset from strap tables.
// - fast-ir base high 03h; low 10h for 011,100,101 else 00h.
module irsm_shared_mem
  import irsm_pkg::*;
#(
  parameter int LEN_W = 14
) (
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic [2:0] op_strap_i,
  input wire logic [2:0] default_strap_i,
  input wire logic host_io_wr_i,
  input wire logic host_io_rd_i,
  input wire logic host_io_data_sel_i,
  input wire logic [7:0] host_data_i,
  output logic [7:0] host_data_o,
  input wire logic host_mem_rd_i,
  input wire logic host_mem_wr_i,
  input wire logic [HOST_ADDR_W-1:0] host_addr_i,
  output logic host_mem_ready_o,
  output logic shared_mode_o,
  output logic [LOCAL_ADDR_W-1:0] local_mem_addr_o,
  output logic local_sram_read_strobe_n_o,
  output logic local_sram_write_strobe_n_o,
  output logic local_sram_select_n_o,
  output logic bus_isolator_enable_n_o,
  output logic bus_isolator_direction_o,
  input wire logic [7:0] local_data_bus_i,
  output logic [7:0] local_data_bus_o,
  output logic local_data_bus_oe_n_o,
  input wire logic fir_tx_start_i,
  input wire logic [LEN_W-1:0] fir_tx_len_i,
  output logic [7:0] fir_tx_data_o,
  output logic fir_tx_valid_o,
  input wire logic fir_tx_ready_i,
  output logic fir_tx_busy_o,
  input wire logic [7:0] fir_rx_data_i,
  input wire logic fir_rx_valid_i,
  input wire logic fir_rx_last_i,
  output logic fir_rx_ready_o,
  output logic rx_packet_done_o,
  output logic [LEN_W-1:0] rx_packet_len_o
);

  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  function automatic logic [7:0] pick(input logic [63:0] tbl,
                                      input logic [2:0] code);
    pick = tbl[{code, 3'b000} +: 8];
  endfunction

  // sram address in one half: start on a 1k boundary plus offset;
  // the sum wraps inside the half so a page never leaves it
  function automatic logic [LOCAL_ADDR_W-1:0] half_addr(
    input logic upper, input logic [3:0] start_kb,
    input logic [HALF_ADDR_W-1:0] ofs);
    logic [HALF_ADDR_W-1:0] base;
    base = HALF_ADDR_W'({start_kb, 10'h000});
    half_addr = {upper, HALF_ADDR_W'(base + ofs)};
  endfunction

  // ------------------------------------------------------------------
  // configuration registers
  // ------------------------------------------------------------------
  logic shared_mode_q;
  logic [7:0] index_q;
  logic [7:0] pdc_q;
  logic [7:0] smds_q;
  logic [7:0] irc_q;
  logic [7:0] sph_q;
  logic [7:0] spl_q;
  logic [7:0] fast_ir_base_high_q;
  logic [7:0] fast_ir_base_low_q;
  logic [6:0] win_base_q;
  logic [3:0] tx_start_q;
  logic [3:0] rx_start_q;
  logic [7:0] rd_val;
  logic cfg_wr;

  assign cfg_wr = host_io_wr_i && host_io_data_sel_i;

  // straps are caught while reset is held
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      shared_mode_q <= (op_strap_i == OP_STRAP_SHARED);
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      index_q <= 8'h00;
    end else if (host_io_wr_i && !host_io_data_sel_i) begin
      index_q <= host_data_i;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      pdc_q <= RST_POWER_DOWN_CONTROL;
      smds_q <= pick(RST_SMDS_TABLE, default_strap_i);
      irc_q <= pick(RST_IRC_TABLE, default_strap_i);
      sph_q <= pick(RST_SP_HIGH_TABLE, default_strap_i);
      spl_q <= pick(RST_SP_LOW_TABLE, default_strap_i);
      fast_ir_base_high_q <= RST_FAST_IR_BASE_HIGH;
      fast_ir_base_low_q <= pick(RST_FIR_LOW_TABLE, default_strap_i);
      win_base_q <= RST_WINDOW_BASE;
      tx_start_q <= RST_PAGE_START;
      rx_start_q <= RST_PAGE_START;
    end else if (cfg_wr) begin
      case (index_q)
        IDX_POWER_DOWN_CONTROL: pdc_q <= host_data_i;
        IDX_SHARED_MEMORY_DMA_SELECT: smds_q <= host_data_i;
        IDX_INTERRUPT_CONFIGURATION: irc_q <= host_data_i;
        IDX_SERIAL_PORT_BASE_HIGH: sph_q <= host_data_i;
        IDX_SERIAL_PORT_BASE_LOW: spl_q <= host_data_i;
        IDX_FAST_IR_BASE_HIGH: fast_ir_base_high_q <= host_data_i;
        IDX_FAST_IR_BASE_LOW: fast_ir_base_low_q <= host_data_i;
        IDX_WINDOW_BASE: win_base_q <= host_data_i[6:0];
        IDX_TX_PAGE_START: tx_start_q <= host_data_i[3:0];
        IDX_RX_PAGE_START: rx_start_q <= host_data_i[3:0];
        default: ; // read-only and unmapped: dropped
      endcase
    end
  end

  always_comb begin
    case (index_q)
      IDX_POWER_DOWN_CONTROL: rd_val = pdc_q;
      IDX_MODE_IDENTIFICATION:
        rd_val = shared_mode_q ? MODE_ID_SHARED : MODE_ID_OTHER;
      IDX_SHARED_MEMORY_DMA_SELECT: rd_val = smds_q;
      IDX_INTERRUPT_CONFIGURATION: rd_val = irc_q;
      IDX_SERIAL_PORT_BASE_HIGH: rd_val = sph_q;
      IDX_SERIAL_PORT_BASE_LOW: rd_val = spl_q;
      IDX_FAST_IR_BASE_HIGH: rd_val = fast_ir_base_high_q;
      IDX_FAST_IR_BASE_LOW: rd_val = fast_ir_base_low_q;
      IDX_WINDOW_BASE: rd_val = {1'b0, win_base_q};
      IDX_TX_PAGE_START: rd_val = {4'h0, tx_start_q};
      IDX_RX_PAGE_START: rd_val = {4'h0, rx_start_q};
      default: rd_val = 8'h00;
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      host_data_o <= 8'h00;
    end else if (host_io_rd_i) begin
      host_data_o <= host_io_data_sel_i ? rd_val : index_q;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      shared_mode_o <= 1'b0;
    end else begin
      shared_mode_o <= shared_mode_q;
    end
  end

  // ------------------------------------------------------------------
  // host window decode
  // ------------------------------------------------------------------
  logic host_hold_q;
  logic win_hit;
  logic host_req;
  logic [LOCAL_ADDR_W-1:0] host_sram_addr;

  assign win_hit = host_addr_i[HOST_ADDR_W-1:WINDOW_SHIFT] == win_base_q;
  // host holds its strobe until ready; hold blocks a repeat
  assign host_req = shared_mode_q && win_hit && !host_hold_q &&
                    (host_mem_rd_i || host_mem_wr_i);
  // upper 4k of the window is transmit, lower 4k receive
  assign host_sram_addr = half_addr(host_addr_i[PAGE_OFS_W],
    host_addr_i[PAGE_OFS_W] ? tx_start_q : rx_start_q,
    HALF_ADDR_W'(host_addr_i[PAGE_OFS_W-1:0]));

  // ------------------------------------------------------------------
  // fast-ir transmit and receive engines
  // ------------------------------------------------------------------
  irsm_arb_type state_q;
  logic [3:0] cnt_q;
  logic last_host_q;
  logic acc_end;
  logic tx_active_q;
  logic [LEN_W-1:0] tx_left_q;
  logic [HALF_ADDR_W-1:0] tx_ofs_q;
  logic [7:0] rx_byte_q;
  logic rx_pend_q;
  logic rx_last_q;
  logic [HALF_ADDR_W-1:0] rx_ofs_q;
  logic [LEN_W-1:0] rx_cnt_q;
  logic fir_rd_req;
  logic fir_wr_req;

  assign acc_end = (state_q != ARB_IDLE) && (cnt_q == ACC_LAST);
  assign fir_rd_req = tx_active_q && !fir_tx_valid_o && (tx_left_q != '0);
  assign fir_wr_req = rx_pend_q;

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      tx_active_q <= 1'b0;
      tx_left_q <= '0;
      tx_ofs_q <= '0;
      fir_tx_valid_o <= 1'b0;
      fir_tx_data_o <= 8'h00;
    end else begin
      if (!tx_active_q && fir_tx_start_i && shared_mode_q) begin
        tx_active_q <= 1'b1;
        tx_left_q <= fir_tx_len_i;
        tx_ofs_q <= '0;
      end else if (tx_active_q && tx_left_q == '0 && !fir_tx_valid_o) begin
        tx_active_q <= 1'b0;
      end
      if (acc_end && state_q == ARB_FIR_RD) begin
        fir_tx_data_o <= local_data_bus_i;
        fir_tx_valid_o <= 1'b1;
        tx_left_q <= tx_left_q - 1'b1;
        tx_ofs_q <= tx_ofs_q + 1'b1;
      end else if (fir_tx_valid_o && fir_tx_ready_i) begin
        fir_tx_valid_o <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      fir_tx_busy_o <= 1'b0;
    end else begin
      fir_tx_busy_o <= tx_active_q;
    end
  end

  // one byte of holding; ready drops until the byte is in sram
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      rx_pend_q <= 1'b0;
      rx_last_q <= 1'b0;
      rx_byte_q <= 8'h00;
      fir_rx_ready_o <= 1'b0;
      rx_ofs_q <= '0;
      rx_cnt_q <= '0;
      rx_packet_done_o <= 1'b0;
      rx_packet_len_o <= '0;
    end else begin
      rx_packet_done_o <= 1'b0;
      if (fir_rx_valid_i && fir_rx_ready_o) begin
        rx_byte_q <= fir_rx_data_i;
        rx_last_q <= fir_rx_last_i;
        rx_pend_q <= 1'b1;
        fir_rx_ready_o <= 1'b0;
      end else if (acc_end && state_q == ARB_FIR_WR) begin
        rx_pend_q <= 1'b0;
        fir_rx_ready_o <= 1'b1;
        if (rx_last_q) begin
          rx_packet_done_o <= 1'b1;
          rx_packet_len_o <= rx_cnt_q + 1'b1;
          rx_ofs_q <= '0;
          rx_cnt_q <= '0;
        end else begin
          rx_ofs_q <= rx_ofs_q + 1'b1;
          rx_cnt_q <= rx_cnt_q + 1'b1;
        end
      end else if (!rx_pend_q) begin
        fir_rx_ready_o <= shared_mode_q;
      end
    end
  end

  // ------------------------------------------------------------------
  // arbiter and sram cycle
  // ------------------------------------------------------------------
  // a running cycle always completes; the grant is only re-decided in
  // idle, which costs one dead cycle between accesses but keeps the
  // buffer and the local drivers from ever overlapping
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      state_q <= ARB_IDLE;
      cnt_q <= 4'h0;
      last_host_q <= 1'b0;
    end else begin
      case (state_q)
        ARB_IDLE: begin
          cnt_q <= 4'h0;
          if (host_req && (fir_wr_req || fir_rd_req)) begin
            // both want the bus: alternate so neither starves
            if (last_host_q) begin
              state_q <= fir_wr_req ? ARB_FIR_WR : ARB_FIR_RD;
              last_host_q <= 1'b0;
            end else begin
              state_q <= ARB_HOST;
              last_host_q <= 1'b1;
            end
          end else if (host_req) begin
            state_q <= ARB_HOST;
            last_host_q <= 1'b1;
          end else if (fir_wr_req) begin
            state_q <= ARB_FIR_WR;
            last_host_q <= 1'b0;
          end else if (fir_rd_req) begin
            state_q <= ARB_FIR_RD;
            last_host_q <= 1'b0;
          end
        end
        ARB_HOST, ARB_FIR_RD, ARB_FIR_WR: begin
          if (acc_end) begin
            state_q <= ARB_IDLE;
          end else begin
            cnt_q <= cnt_q + 1'b1;
          end
        end
        default: state_q <= ARB_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      host_hold_q <= 1'b0;
      host_mem_ready_o <= 1'b0;
    end else begin
      host_mem_ready_o <= acc_end && state_q == ARB_HOST;
      if (acc_end && state_q == ARB_HOST) begin
        host_hold_q <= 1'b1;
      end else if (!host_mem_rd_i && !host_mem_wr_i) begin
        host_hold_q <= 1'b0;
      end
    end
  end

  // sram pins registered; strobes fall with the grant and rise at the end
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      local_mem_addr_o <= '0;
      local_sram_select_n_o <= 1'b1;
      local_sram_read_strobe_n_o <= 1'b1;
      local_sram_write_strobe_n_o <= 1'b1;
      bus_isolator_enable_n_o <= 1'b1;
      bus_isolator_direction_o <= 1'b0;
      local_data_bus_o <= 8'h00;
      local_data_bus_oe_n_o <= 1'b1;
    end else if (state_q == ARB_IDLE) begin
      local_sram_select_n_o <= 1'b1;
      local_sram_read_strobe_n_o <= 1'b1;
      local_sram_write_strobe_n_o <= 1'b1;
      bus_isolator_enable_n_o <= 1'b1;
      local_data_bus_oe_n_o <= 1'b1;
      if (host_req && !(last_host_q && (fir_wr_req || fir_rd_req))) begin
        local_mem_addr_o <= host_sram_addr;
        local_sram_select_n_o <= 1'b0;
        local_sram_read_strobe_n_o <= !host_mem_rd_i;
        local_sram_write_strobe_n_o <= host_mem_rd_i;
        bus_isolator_enable_n_o <= 1'b0;
        bus_isolator_direction_o <= !host_mem_rd_i;
      end else if (fir_wr_req) begin
        local_mem_addr_o <= half_addr(1'b0, rx_start_q, rx_ofs_q);
        local_sram_select_n_o <= 1'b0;
        local_sram_write_strobe_n_o <= 1'b0;
        local_data_bus_o <= rx_byte_q;
        local_data_bus_oe_n_o <= 1'b0;
      end else if (fir_rd_req) begin
        local_mem_addr_o <= half_addr(1'b1, tx_start_q, tx_ofs_q);
        local_sram_select_n_o <= 1'b0;
        local_sram_read_strobe_n_o <= 1'b0;
      end
    end else if (acc_end) begin
      local_sram_select_n_o <= 1'b1;
      local_sram_read_strobe_n_o <= 1'b1;
      local_sram_write_strobe_n_o <= 1'b1;
      bus_isolator_enable_n_o <= 1'b1;
      local_data_bus_oe_n_o <= 1'b1;
    end
  end

endmodule

// File: pkg/irsm_pkg.sv
// constants for the shared-memory interface of the infrared controller
package irsm_pkg;

  // ------------------------------------------------------------------
  // configuration register indices
  // ------------------------------------------------------------------
  localparam logic [7:0] IDX_POWER_DOWN_CONTROL = 8'h02;
  localparam logic [7:0] IDX_MODE_IDENTIFICATION = 8'h08;
  localparam logic [7:0] IDX_SHARED_MEMORY_DMA_SELECT = 8'ha2;
  localparam logic [7:0] IDX_INTERRUPT_CONFIGURATION = 8'ha3;
  localparam logic [7:0] IDX_SERIAL_PORT_BASE_HIGH = 8'ha4;
  localparam logic [7:0] IDX_SERIAL_PORT_BASE_LOW = 8'ha5;
  localparam logic [7:0] IDX_FAST_IR_BASE_HIGH = 8'ha6;
  localparam logic [7:0] IDX_FAST_IR_BASE_LOW = 8'ha7;
  localparam logic [7:0] IDX_WINDOW_BASE = 8'ha8;
  localparam logic [7:0] IDX_TX_PAGE_START = 8'ha9;
  localparam logic [7:0] IDX_RX_PAGE_START = 8'haa;

  // ------------------------------------------------------------------
  // reset values; tables indexed by default strap code
  // ------------------------------------------------------------------
  localparam logic [7:0] RST_POWER_DOWN_CONTROL = 8'h02;
  localparam logic [7:0] MODE_ID_SHARED = 8'he3;
  localparam logic [7:0] MODE_ID_OTHER = 8'he2;
  localparam logic [7:0] RST_FAST_IR_BASE_HIGH = 8'h03;
  localparam logic [63:0] RST_SMDS_TABLE =
    64'hd4_c4_d0_c8_00_00_00_00;
  localparam logic [63:0] RST_IRC_TABLE =
    64'h21_21_25_21_05_01_05_04;
  localparam logic [63:0] RST_SP_HIGH_TABLE =
    64'h02_02_03_02_03_02_03_03;
  localparam logic [63:0] RST_SP_LOW_TABLE =
    64'hf8_f8_e8_e8_e8_f8_f8_f8;
  localparam logic [63:0] RST_FIR_LOW_TABLE =
    64'h00_00_10_10_10_00_00_00;
  localparam logic [6:0] RST_WINDOW_BASE = 7'h64;
  localparam logic [3:0] RST_PAGE_START = 4'h0;

  // ------------------------------------------------------------------
  // operating mode strap and memory layout
  // ------------------------------------------------------------------
  localparam logic [2:0] OP_STRAP_SHARED = 3'b011;
  localparam int HOST_ADDR_W = 20;
  localparam int LOCAL_ADDR_W = 15;
  localparam int HALF_ADDR_W = 14;
  localparam int PAGE_OFS_W = 12;
  localparam int KB_SHIFT = 10;
  localparam int WINDOW_SHIFT = 13;

  // ------------------------------------------------------------------
  // timing
  // ------------------------------------------------------------------
  localparam int CLK_MHZ = 200;
  localparam int SRAM_ACCESS_NS = 15;
  localparam int SRAM_ACCESS_CYC =
    ((SRAM_ACCESS_NS * CLK_MHZ + 999) / 1000 < 1) ? 1 :
    (SRAM_ACCESS_NS * CLK_MHZ + 999) / 1000;
  localparam logic [3:0] ACC_LAST = 4'(SRAM_ACCESS_CYC - 1);

  typedef enum logic [1:0] {
    ARB_IDLE,
    ARB_HOST,
    ARB_FIR_RD,
    ARB_FIR_WR
  } irsm_arb_type;

endpackage

// File: sim/irsm_shared_mem_sva.sv
// assertions for the shared-memory sram controller
module irsm_shared_mem_sva
  import irsm_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic host_mem_rd_i,
  input wire logic host_mem_wr_i,
  input wire logic host_mem_ready_o,
  input wire logic [LOCAL_ADDR_W-1:0] local_mem_addr_o,
  input wire logic local_sram_read_strobe_n_o,
  input wire logic local_sram_write_strobe_n_o,
  input wire logic local_sram_select_n_o,
  input wire logic bus_isolator_enable_n_o,
  input wire logic bus_isolator_direction_o,
  input wire logic local_data_bus_oe_n_o,
  input wire logic [7:0] fir_tx_data_o,
  input wire logic fir_tx_valid_o,
  input wire logic fir_tx_ready_i,
  input wire logic rx_packet_done_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);
  // ----------------------------------------------------------------
  // sequences
  // ----------------------------------------------------------------
  sequence s_access;
    !local_sram_select_n_o [*3] ##1 local_sram_select_n_o;
  endsequence
  sequence s_host_req;
    $rose(host_mem_rd_i || host_mem_wr_i);
  endsequence
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  a_access_length: assert property (
    $fell(local_sram_select_n_o) |-> s_access)
    else $error("sram access length wrong");
  a_host_answer: assert property (
    s_host_req |-> ##[4:14] host_mem_ready_o)
    else $error("host cycle not answered");
  a_ready_shape: assert property (
    host_mem_ready_o |-> local_sram_select_n_o &&
      !$past(bus_isolator_enable_n_o))
    else $error("ready misplaced");
  a_no_iso_own: assert property (
    !local_data_bus_oe_n_o |-> bus_isolator_enable_n_o)
    else $error("buffer on while driving");
  a_iso_direction: assert property (
    !bus_isolator_enable_n_o |->
      bus_isolator_direction_o == !local_sram_write_strobe_n_o)
    else $error("buffer direction wrong");
  a_tx_upper_half: assert property (
    !local_sram_read_strobe_n_o && bus_isolator_enable_n_o |->
      local_mem_addr_o[14])
    else $error("tx read not in upper half");
  a_rx_lower_half: assert property (
    !local_sram_write_strobe_n_o && bus_isolator_enable_n_o |->
      !local_mem_addr_o[14] && !local_data_bus_oe_n_o)
    else $error("rx write not in lower half");
  a_addr_stable: assert property (
    !local_sram_select_n_o && !$past(local_sram_select_n_o) |->
      $stable(local_mem_addr_o))
    else $error("sram address moved in access");
  a_tx_hold: assert property (
    fir_tx_valid_o && !fir_tx_ready_i |=>
      fir_tx_valid_o && $stable(fir_tx_data_o))
    else $error("tx byte lost in stall");
  a_done_pulse: assert property (
    rx_packet_done_o |=> !rx_packet_done_o)
    else $error("done not a pulse");
endmodule

bind irsm_shared_mem irsm_shared_mem_sva u_sva (
  .ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
  .host_mem_rd_i(host_mem_rd_i), .host_mem_wr_i(host_mem_wr_i),
  .host_mem_ready_o(host_mem_ready_o),
  .local_mem_addr_o(local_mem_addr_o),
  .local_sram_read_strobe_n_o(local_sram_read_strobe_n_o),
  .local_sram_write_strobe_n_o(local_sram_write_strobe_n_o),
  .local_sram_select_n_o(local_sram_select_n_o),
  .bus_isolator_enable_n_o(bus_isolator_enable_n_o),
  .bus_isolator_direction_o(bus_isolator_direction_o),
  .local_data_bus_oe_n_o(local_data_bus_oe_n_o),
  .fir_tx_data_o(fir_tx_data_o), .fir_tx_valid_o(fir_tx_valid_o),
  .fir_tx_ready_i(fir_tx_ready_i), .rx_packet_done_o(rx_packet_done_o));

// File: sim/irsm_sram_model.sv
// local sram model at the far side
module irsm_sram_model (
  input wire logic clk_i,
  input wire logic [14:0] addr_i,
  input wire logic rd_n_i,
  input wire logic wr_n_i,
  input wire logic sel_n_i,
  input wire logic [7:0] data_i,
  output logic [7:0] data_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [32768];
  logic [7:0] last_q = 8'h00;
  // released bus shows inverse of last byte
  assign data_o = (!sel_n_i && !rd_n_i) ? mem[addr_i] : ~last_q;
  always @(posedge clk_i) begin
    if (!sel_n_i && !rd_n_i)
      last_q <= mem[addr_i];
    if (!sel_n_i && !wr_n_i)
      mem[addr_i] <= data_i;
  end
endmodule

// File: sim/irsm_shared_mem_tb.sv
// testbench for the shared-memory sram controller
module irsm_shared_mem_tb
  import irsm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int LW = 14;
  localparam logic [7:0] IDX [8] = '{8'h02, 8'h08, 8'ha2, 8'ha3,
    8'ha4, 8'ha5, 8'ha6, 8'ha7};
  logic clk = 0, rst = 1, iwr = 0, ird = 0, isel = 0, mrd = 0, mwr = 0;
  logic [2:0] op = 3'b011, df = 3'h0;
  logic [7:0] hd = 8'h00, rxd = 8'h00, lbo, lbi, txd, hdo, sq, cap;
  logic [19:0] ha = 20'h00000;
  logic rdy, smode, rdn, wrn, seln, ien, idir, oen, txb, rxr, done, txv;
  logic txs = 0, txr = 0, rxv = 0, rxl = 0, rd_q = 0;
  logic [14:0] ma;
  logic [LW-1:0] txl = 14'h0000, rlen;
  logic [7:0] eq_cfg[$], eq_mem[$], eq_tx[$], tb_tx[16], tb_rx[16];
  logic [LW-1:0] eq_len[$];
  logic [31:0] st = 32'h47;
  int fails = 0, checks = 0;

  always #2.5 clk = ~clk;
  // buffer and device drivers onto the local bus
  assign lbi = !oen ? lbo : (!ien && idir) ? hd : sq;

  irsm_shared_mem #(.LEN_W(LW)) dut (.ref_clk_i(clk), .sys_rst_i(rst),
    .op_strap_i(op), .default_strap_i(df), .host_io_wr_i(iwr),
    .host_io_rd_i(ird), .host_io_data_sel_i(isel), .host_data_i(hd),
    .host_data_o(hdo), .host_mem_rd_i(mrd), .host_mem_wr_i(mwr),
    .host_addr_i(ha), .host_mem_ready_o(rdy), .shared_mode_o(smode),
    .local_mem_addr_o(ma), .local_sram_read_strobe_n_o(rdn),
    .local_sram_write_strobe_n_o(wrn), .local_sram_select_n_o(seln),
    .bus_isolator_enable_n_o(ien), .bus_isolator_direction_o(idir),
    .local_data_bus_i(lbi), .local_data_bus_o(lbo),
    .local_data_bus_oe_n_o(oen), .fir_tx_start_i(txs),
    .fir_tx_len_i(txl), .fir_tx_data_o(txd), .fir_tx_valid_o(txv),
    .fir_tx_ready_i(txr), .fir_tx_busy_o(txb), .fir_rx_data_i(rxd),
    .fir_rx_valid_i(rxv), .fir_rx_last_i(rxl), .fir_rx_ready_o(rxr),
    .rx_packet_done_o(done), .rx_packet_len_o(rlen));
  irsm_sram_model sram (.clk_i(clk), .addr_i(ma), .rd_n_i(rdn),
    .wr_n_i(wrn), .sel_n_i(seln), .data_i(lbi), .data_o(sq));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] rnd();
    st ^= st << 13;
    st ^= st >> 17;
    st ^= st << 5;
    return st;
  endfunction
  function automatic logic [7:0] rv(input logic [7:0] i, input int c);
    case (i)
      8'h02: return 8'h02;
      8'h08: return 8'he3;
      8'ha2: return RST_SMDS_TABLE[c*8 +: 8];
      8'ha3: return RST_IRC_TABLE[c*8 +: 8];
      8'ha4: return RST_SP_HIGH_TABLE[c*8 +: 8];
      8'ha5: return RST_SP_LOW_TABLE[c*8 +: 8];
      8'ha7: return RST_FIR_LOW_TABLE[c*8 +: 8];
      default: return 8'h03;
    endcase
  endfunction
  task automatic check_byte(input logic [7:0] g, input logic [7:0] e);
    checks++;
    if (g !== e) begin
      fails++;
      $display("ERROR %0t byte %h not %h", $time, g, e);
    end
  endtask
  task automatic check_len(input logic [LW-1:0] g, input logic [LW-1:0] e);
    checks++;
    if (g !== e) begin
      fails++;
      $display("ERROR %0t length %h not %h", $time, g, e);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic timeout();
    fails++;
    $display("ERROR %0t wait ran out", $time);
    report_and_stop();
  endtask
  task automatic do_reset(input logic [2:0] o, input logic [2:0] d);
    @(negedge clk);
    rst = 1;
    op = o;
    df = d;
    repeat (10) @(negedge clk);
    rst = 0;
  endtask
  task automatic cfg_wr(input logic [7:0] i, input logic [7:0] v,
                        input logic r = 0);
    @(negedge clk);
    iwr = 1;
    isel = 0;
    hd = i;
    @(negedge clk);
    iwr = !r;
    ird = r;
    isel = 1;
    hd = v;
    @(negedge clk);
    iwr = 0;
    ird = 0;
  endtask
  task automatic cfg_rd(input logic [7:0] i, input logic [7:0] e);
    eq_cfg.push_back(e);
    cfg_wr(i, 8'h00, 1);
  endtask
  task automatic mem(input logic w, input logic [19:0] a,
                     input logic [7:0] d);
    int n;
    @(negedge clk);
    ha = a;
    hd = d;
    mwr = w;
    mrd = !w;
    if (!w)
      eq_mem.push_back(d);
    n = 0;
    do @(posedge clk); while (!rdy && ++n < 40);
    if (!rdy)
      timeout();
    @(negedge clk);
    mwr = 0;
    mrd = 0;
  endtask
  task automatic rx_byte(input logic [7:0] d, input logic last);
    int n;
    @(negedge clk);
    rxv = 1;
    rxd = d;
    rxl = last;
    n = 0;
    do @(posedge clk); while (!rxr && ++n < 40);
    if (!rxr)
      timeout();
    @(negedge clk);
    rxv = 0;
    rxl = 0;
  endtask

  // ----------------------------------------------------------------
  // monitor: each result against the oldest note
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    if (rd_q)
      check_byte(hdo, eq_cfg.size() ? eq_cfg.pop_front() : 8'hxx);
    rd_q = ird;
    if (!ien && !idir && !rdn)
      cap = lbi;
    if (rdy && mrd)
      check_byte(cap, eq_mem.size() ? eq_mem.pop_front() : 8'hxx);
    if (txv && txr)
      check_byte(txd, eq_tx.size() ? eq_tx.pop_front() : 8'hxx);
    if (done)
      check_len(rlen, eq_len.size() ? eq_len.pop_front() : 'x);
  end
  // far side stalls the transmit stream at random
  always @(negedge clk) txr <= ~txr | st[3];

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [7:0] v;
    logic u;
    int tp, rp, ofs, n, m;
    for (int c = 0; c < 8; c++) begin
      do_reset(3'b011, 3'(c));
      foreach (IDX[k]) cfg_rd(IDX[k], rv(IDX[k], c));
      v = 8'(rnd());
      cfg_wr(8'h02, v);
      cfg_rd(8'h02, v);
      cfg_wr(8'h08, v);
      cfg_rd(8'h08, 8'he3);
      cfg_rd(8'h55, 8'h00);
    end
    $display("test register defaults done");
    do_reset(3'b000, 3'b001);
    cfg_rd(8'h08, 8'he2);
    @(negedge clk);
    check_byte({7'h00, smode}, 8'h00);
    do_reset(3'b011, 3'b011);
    tp = int'(rnd() & 15);
    rp = int'(rnd() & 15);
    cfg_wr(8'ha9, 8'(tp));
    check_byte({7'h00, smode}, 8'h01);
    cfg_wr(8'haa, 8'(rp));
    for (int k = 0; k < 8; k++) begin
      u = k[0];
      ofs = int'(rnd() & 32'hfff);
      v = 8'(rnd());
      mem(1, 20'hc8000 | {7'h00, u, 12'(ofs)}, v);
      check_byte(sram.mem[{u, 14'((u ? tp : rp) * 1024 + ofs)}], v);
      mem(0, 20'hc8000 | {7'h00, u, 12'(ofs)}, v);
    end
    $display("test window paging done");
    cfg_wr(8'ha9, 8'h00);
    cfg_wr(8'haa, 8'h00);
    n = 4 + int'(rnd() & 7);
    m = 3 + int'(rnd() & 7);
    for (int i = 0; i < n; i++) begin
      tb_tx[i] = 8'(rnd());
      mem(1, 20'hc9000 + 20'(i), tb_tx[i]);
      eq_tx.push_back(tb_tx[i]);
    end
    eq_len.push_back(14'(m));
    @(negedge clk);
    txl = 14'(n);
    txs = 1;
    @(negedge clk);
    txs = 0;
    fork
      for (int i = 0; i < m; i++) begin
        tb_rx[i] = 8'(rnd());
        rx_byte(tb_rx[i], i == m - 1);
      end
      for (int i = 0; i < n; i++)
        mem(0, 20'hc9000 + 20'(i), tb_tx[i]);
    join
    for (int k = 0; k < 400 && (txb || eq_tx.size() > 0); k++)
      @(posedge clk);
    if (eq_tx.size() > 0)
      timeout();
    for (int i = 0; i < m; i++)
      mem(0, 20'hc8000 + 20'(i), tb_rx[i]);
    check_byte(8'(eq_cfg.size() + eq_mem.size() + eq_len.size()), 8'h00);
    $display("test transmit and receive done");
    report_and_stop();
  end
endmodule
